// ---- design/ext_bus_pkg.sv ----
package ext_bus_pkg;

  // Access spaces requested by the core
  typedef enum logic [1:0]
  {
    SPACE_PROGRAM,
    SPACE_DATA,
    SPACE_IO
  } space_t;

  // Field position of the read-pin function bit in the processor mode register
  localparam int unsigned READ_PIN_FUNC_BIT = 15;
  // Mode bit position in the interrupt control register (0 selects hold)
  localparam int unsigned HOLD_MODE_BIT     = 0;
  // Reset values of the two mode registers
  localparam logic [15:0] MODE_REG_RESET    = 16'h0000;
  localparam logic [15:0] INT_CTRL_RESET    = 16'h0000;
  // Bus widths
  localparam int unsigned ADDR_W            = 16;
  localparam int unsigned DATA_W            = 16;
  // Machine cycle is this many clk_sys cycles (divider for the enable pulse)
  localparam int unsigned MC_DIV            = 4;
  localparam logic [1:0]  MC_DIV_LAST       = 2'(MC_DIV - 1);

endpackage

// ---- design/bus_ctl_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Bus cycle state handed from the sequencer to the pin stage
interface bus_ctl_if;
  import ext_bus_pkg::*;
  logic                active;  // External cycle in progress
  logic                write;   // Cycle is a write
  ext_bus_pkg::space_t space;   // Target space
  logic                glb;     // Global data access
  modport seq (output active, output write, output space, output glb);
  modport pins (input active, input write, input space, input glb);
endinterface
`default_nettype wire

// ---- design/bus_cycle_seq.sv ----
`timescale 1ns/1ns
`default_nettype none
// Machine-cycle sequencer: accepts a request and stretches it on ready low
module bus_cycle_seq
(
  input  wire logic                 clk_sys,  // System clock
  input  wire logic                 rstn,     // Synchronous reset, low active
  input  wire logic                 mc_tick,  // Machine-cycle enable pulse
  input  wire logic                 req,      // Access request level
  input  wire logic                 req_wr,   // Request is a write
  input  wire ext_bus_pkg::space_t  req_space,// Request space
  input  wire logic                 req_glb,  // Request is global data
  input  wire logic                 ready,    // External ready
  input  wire logic                 hold,     // Hold state, blocks new cycles
  output logic                      done,     // One-cycle completion pulse
  bus_ctl_if.seq                    ctl       // Cycle state out
);
  import ext_bus_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_BUSY} seq_state_t;

  seq_state_t          state_reg, state_next;  // Sequencer state
  logic                wr_reg, wr_next;        // Latched direction
  space_t              sp_reg, sp_next;        // Latched space
  logic                glb_reg, glb_next;      // Latched global flag
  logic                done_reg, done_next;    // Completion pulse

  // Next state: cycles start and end on machine-cycle boundaries only
  always_comb
  begin
    state_next = state_reg;
    wr_next    = wr_reg;
    sp_next    = sp_reg;
    glb_next   = glb_reg;
    done_next  = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        // Hold keeps the bus free for other masters
        if (mc_tick && req && !hold)
        begin
          state_next = ST_BUSY;
          wr_next    = req_wr;
          sp_next    = req_space;
          glb_next   = req_glb;
        end
      end
      ST_BUSY:
      begin
        // Ready low adds one machine cycle, then it is sampled again
        if (mc_tick && ready)
        begin
          state_next = ST_IDLE;
          done_next  = 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      wr_reg    <= 1'b0;
      sp_reg    <= SPACE_PROGRAM;
      glb_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wr_reg    <= wr_next;
      sp_reg    <= sp_next;
      glb_reg   <= glb_next;
      done_reg  <= done_next;
    end
  end

  assign ctl.active = (state_reg == ST_BUSY);
  assign ctl.write  = wr_reg;
  assign ctl.space  = sp_reg;
  assign ctl.glb    = glb_reg;
  assign done       = done_reg;

endmodule // bus_cycle_seq
`default_nettype wire

// ---- design/ext_bus_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module ext_bus_ctrl
(
  input  wire logic                              clk_sys,       // 250 MHz clock
  input  wire logic                              rstn,          // Synchronous reset, low
  input  wire logic                              output_off_n,  // Output disable, low
  input  wire logic                              ready,         // External ready
  input  wire logic                              hold_req_n,    // Hold/interrupt pin, low
  input  wire logic                              req,           // Core access request
  input  wire logic                              req_wr,        // Request is a write
  input  wire ext_bus_pkg::space_t               req_space,     // Request space
  input  wire logic                              req_glb,       // Global data access
  input  wire logic [ext_bus_pkg::ADDR_W-1:0]    req_addr,      // Request address
  input  wire logic [ext_bus_pkg::DATA_W-1:0]    req_wdata,     // Write data
  input  wire logic                              mode_wr,       // Write mode register
  input  wire logic                              int_ctrl_wr,   // Write interrupt control
  input  wire logic [15:0]                       cfg_wdata,     // Data for those writes
  input  wire logic [ext_bus_pkg::DATA_W-1:0]    data_in,       // Data pins, input
  output logic                                   req_done,      // Access complete pulse
  output logic [ext_bus_pkg::DATA_W-1:0]         rdata,         // Captured read data
  output logic                                   hold_active,   // Hold state to the core
  output logic                                   program_space_select_n, // Program select
  output logic                                   program_space_select_oe,// Its enable
  output logic                                   data_space_select_n,    // Data select
  output logic                                   data_space_select_oe,   // Its enable
  output logic                                   io_space_select_n,      // I/O select
  output logic                                   io_space_select_oe,     // Its enable
  output logic                                   rw_dir,        // Direction, low on write
  output logic                                   rw_dir_oe,     // Its enable
  output logic                                   read_strobe_n, // Read pin
  output logic                                   read_strobe_oe,// Its enable
  output logic                                   write_strobe_n,// Write strobe
  output logic                                   write_strobe_oe,// Its enable
  output logic                                   bus_cycle_strobe_n,  // Bus strobe
  output logic                                   bus_cycle_strobe_oe, // Its enable
  output logic                                   global_bus_request_n, // Bus request
  output logic                                   global_bus_request_oe,// Its enable
  output logic                                   hold_acknowledge_n,   // Hold acknowledge
  output logic                                   hold_acknowledge_oe,  // Its enable
  output logic [ext_bus_pkg::ADDR_W-1:0]         addr_out,      // Address pins
  output logic                                   addr_oe,       // Address enable
  output logic [ext_bus_pkg::DATA_W-1:0]         data_out,      // Data pins, output
  output logic                                   data_oe        // Data enable
);
  import ext_bus_pkg::*;

  bus_ctl_if ctl ();  // Cycle state from the sequencer

  // Machine-cycle divider
  logic [1:0]  div_reg, div_next;      // Divider count
  logic        tick;                   // Machine-cycle enable
  // Mode registers
  logic [15:0] mode_reg, mode_next;    // Processor mode register
  logic [15:0] ictl_reg, ictl_next;    // Interrupt control register
  // Hold and address latch
  logic        hold_reg, hold_next;    // Hold state
  logic [ADDR_W-1:0] addr_reg, addr_next;    // Address held for the cycle
  logic [DATA_W-1:0] wdat_reg, wdat_next;    // Write data held for the cycle
  logic [DATA_W-1:0] rdat_reg, rdat_next;    // Read data capture
  logic        seq_done;               // Completion from sequencer
  // Pin registers, all outputs straight from flops
  logic        prog_sel_reg, prog_sel_next, data_sel_reg, data_sel_next; // Space selects
  logic        is_reg, is_next;                                          // I/O select
  logic        rw_reg, rw_next, rd_reg, rd_next, we_reg, we_next;   // Direction, strobes
  logic        st_reg, st_next, busreq_reg, busreq_next, ha_reg, ha_next; // Bus, request, ack
  logic        oe_reg, oe_next;        // Control enable
  logic        doe_reg, doe_next;      // Data enable
  logic        aoe_reg, aoe_next;      // Address enable
  logic        wlate_reg, wlate_next;  // Write strobe seen low last cycle

  // Writes occur and are done by machine cycles, decoupled from pin timing
  bus_cycle_seq bus_cycle_seq_inst
  (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .mc_tick   (tick),
    .req       (req),
    .req_wr    (req_wr),
    .req_space (req_space),
    .req_glb   (req_glb),
    .ready     (ready),
    .hold      (hold_reg),
    .done      (seq_done),
    .ctl       (ctl.seq)
  );

  assign tick = (div_reg == MC_DIV_LAST);

  // Next values of divider, mode registers, hold state and latches
  always_comb
  begin
    div_next  = tick ? 2'h0 : div_reg + 2'h1;
    mode_next = mode_wr ? cfg_wdata : mode_reg;
    ictl_next = int_ctrl_wr ? cfg_wdata : ictl_reg;
    // Hold only when the pin is in hold mode and no cycle is in progress
    // A cycle taken on this very tick keeps hold out, else its pins would float mid-cycle
    hold_next = !ictl_reg[HOLD_MODE_BIT] && !hold_req_n && !ctl.active
                && !(tick && req && !hold_reg);
    addr_next = (req && tick && !ctl.active) ? req_addr : addr_reg;
    wdat_next = (req && tick && !ctl.active) ? req_wdata : wdat_reg;
    rdat_next = (ctl.active && !ctl.write && tick && ready) ? data_in : rdat_reg;
  end

  // Next values of the pins
  always_comb
  begin
    // One select at most: the space is a single encoded value
    prog_sel_next = !(ctl.active && ctl.space == SPACE_PROGRAM);
    data_sel_next = !(ctl.active && ctl.space == SPACE_DATA);
    is_next = !(ctl.active && ctl.space == SPACE_IO);
    st_next = !ctl.active;
    rw_next = !(ctl.active && ctl.write);
    we_next = !(ctl.active && ctl.write);
    busreq_next = !(ctl.active && ctl.glb && ctl.space == SPACE_DATA);
    ha_next = !hold_reg;
    // Bit 15 set turns the read pin into inverted direction
    if (mode_reg[READ_PIN_FUNC_BIT])
      rd_next = !rw_next;
    else
      rd_next = !(ctl.active && !ctl.write);
    wlate_next = !we_next;
    // Drive data once the write strobe has fallen; float otherwise
    doe_next = output_off_n && !hold_reg && wlate_reg && !we_next;
    oe_next  = output_off_n && !hold_reg;
    aoe_next = output_off_n && !hold_reg;
  end

  // Registers; reset leaves the bus idle and data floating
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      div_reg   <= 2'h0;
      mode_reg  <= MODE_REG_RESET;
      ictl_reg  <= INT_CTRL_RESET;
      hold_reg  <= 1'b0;
      addr_reg  <= 16'h0000;
      wdat_reg  <= 16'h0000;
      rdat_reg  <= 16'h0000;
      prog_sel_reg <= 1'b1;
      data_sel_reg <= 1'b1;
      is_reg    <= 1'b1;
      st_reg    <= 1'b1;
      rw_reg    <= 1'b1;
      rd_reg    <= 1'b1;
      we_reg    <= 1'b1;
      busreq_reg <= 1'b1;
      ha_reg    <= 1'b1;
      wlate_reg <= 1'b0;
      doe_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      aoe_reg   <= 1'b0;
    end
    else
    begin
      div_reg   <= div_next;
      mode_reg  <= mode_next;
      ictl_reg  <= ictl_next;
      hold_reg  <= hold_next;
      addr_reg  <= addr_next;
      wdat_reg  <= wdat_next;
      rdat_reg  <= rdat_next;
      prog_sel_reg <= prog_sel_next;
      data_sel_reg <= data_sel_next;
      is_reg    <= is_next;
      st_reg    <= st_next;
      rw_reg    <= rw_next;
      rd_reg    <= rd_next;
      we_reg    <= we_next;
      busreq_reg <= busreq_next;
      ha_reg    <= ha_next;
      wlate_reg <= wlate_next;
      doe_reg   <= doe_next;
      oe_reg    <= oe_next;
      aoe_reg   <= aoe_next;
    end
  end

  // Hold acknowledge stays enabled in hold; only output disable and reset float it
  logic ha_oe_reg;  // Acknowledge enable
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      ha_oe_reg <= 1'b0;
    else
      ha_oe_reg <= output_off_n;
  end

  assign req_done                = seq_done;
  assign rdata                   = rdat_reg;
  assign hold_active             = hold_reg;
  assign program_space_select_n  = prog_sel_reg;
  assign program_space_select_oe = oe_reg;
  assign data_space_select_n     = data_sel_reg;
  assign data_space_select_oe    = oe_reg;
  assign io_space_select_n       = is_reg;
  assign io_space_select_oe      = oe_reg;
  assign rw_dir                  = rw_reg;
  assign rw_dir_oe               = oe_reg;
  assign read_strobe_n           = rd_reg;
  assign read_strobe_oe          = oe_reg;
  assign write_strobe_n          = we_reg;
  assign write_strobe_oe         = oe_reg;
  assign bus_cycle_strobe_n      = st_reg;
  assign bus_cycle_strobe_oe     = oe_reg;
  assign global_bus_request_n    = busreq_reg;
  assign global_bus_request_oe   = oe_reg;
  assign hold_acknowledge_n      = ha_reg;
  assign hold_acknowledge_oe     = ha_oe_reg;
  assign addr_out                = addr_reg;
  assign addr_oe                 = aoe_reg;
  assign data_out                = wdat_reg;
  assign data_oe                 = doe_reg;

endmodule // ext_bus_ctrl
`default_nettype wire

// ---- verification/ext_bus_ctrl_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module ext_bus_ctrl_props
(
  input  wire logic        clk_sys,                 // Clock
  input  wire logic        rstn,                    // Reset, low
  input  wire logic        output_off_n,            // Output disable
  input  wire logic        ready,                   // Ready in
  input  wire logic        mode_wr,                 // Mode write
  input  wire logic [15:0] cfg_wdata,               // Mode data
  input  wire logic        req_done,                // Done pulse
  input  wire logic        program_space_select_n,  // Program select
  input  wire logic        program_space_select_oe, // Its enable
  input  wire logic        data_space_select_n,     // Data select
  input  wire logic        data_space_select_oe,    // Its enable
  input  wire logic        io_space_select_n,       // I/O select
  input  wire logic        io_space_select_oe,      // Its enable
  input  wire logic        rw_dir,                  // Direction
  input  wire logic        read_strobe_n,           // Read pin
  input  wire logic        read_strobe_oe,          // Its enable
  input  wire logic        write_strobe_n,          // Write strobe
  input  wire logic        bus_cycle_strobe_n,      // Bus strobe
  input  wire logic        global_bus_request_n,    // Bus request
  input  wire logic        hold_acknowledge_n,      // Hold ack
  input  wire logic        hold_acknowledge_oe,     // Its enable
  input  wire logic        addr_oe,                 // Address enable
  input  wire logic        data_oe                  // Data enable
);
  import ext_bus_pkg::*;
  logic mode_reg; // Shadow of the read pin function bit
  logic mode_next; // Its next value
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Shadow the mode bit so the read pin can be judged without seeing inside
  always_comb mode_next = mode_wr ? cfg_wdata[READ_PIN_FUNC_BIT] : mode_reg;
  always_ff @(posedge clk_sys) mode_reg <= rstn ? mode_next : 1'b0;
  idle_selects_a: assert property (bus_cycle_strobe_n |-> program_space_select_n
    && data_space_select_n && io_space_select_n) else $error("select low outside a cycle");
  one_space_a: assert property ($onehot0({~program_space_select_n,
    ~data_space_select_n, ~io_space_select_n})) else $error("two selects low");
  off_floats_a: assert property (!output_off_n |=> !(program_space_select_oe
    | data_space_select_oe | io_space_select_oe | read_strobe_oe | hold_acknowledge_oe
    | addr_oe | data_oe)) else $error("output still driven while disabled");
  write_dir_a: assert property (!write_strobe_n |-> !rw_dir && !bus_cycle_strobe_n)
    else $error("write strobe without write direction");
  data_drive_a: assert property (data_oe |-> !rw_dir)
    else $error("data driven outside a write");
  read_pin_a: assert property (!mode_reg && !$past(mode_reg) && !read_strobe_n
    |-> rw_dir && !bus_cycle_strobe_n) else $error("read strobe outside a read");
  read_inv_a: assert property (mode_reg && $past(mode_reg) && read_strobe_oe
    |-> read_strobe_n == !rw_dir) else $error("read pin not inverted direction");
  ready_done_a: assert property (req_done |-> $past(ready))
    else $error("cycle ended on ready low");
  done_pulse_a: assert property (req_done |=> !req_done) else $error("done longer than one cycle");
  hold_float_a: assert property (!hold_acknowledge_n && hold_acknowledge_oe
    |-> !addr_oe && !data_oe && !program_space_select_oe) else $error("bus driven in hold");
  breq_data_a: assert property ($fell(global_bus_request_n) |-> ##[0:2] !data_space_select_n)
    else $error("bus request without data access");
  // Main scenarios
  wait_c: cover property (!ready && !bus_cycle_strobe_n ##[1:8] req_done);
  write_c: cover property (!write_strobe_n);
  hold_c: cover property (!hold_acknowledge_n && hold_acknowledge_oe);
endmodule // ext_bus_ctrl_props
bind ext_bus_ctrl ext_bus_ctrl_props ext_bus_ctrl_props_inst (.*);
`default_nettype wire

// ---- verification/ext_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model
(
  input  wire logic                           clk_sys,                // Clock
  input  wire logic                           program_space_select_n, // Program select
  input  wire logic                           data_space_select_n,    // Data select
  input  wire logic                           io_space_select_n,      // I/O select
  input  wire logic                           read_strobe_n,          // Read pin
  input  wire logic                           write_strobe_n,         // Write strobe
  input  wire logic                           bus_cycle_strobe_n,     // Bus strobe
  input  wire logic [ext_bus_pkg::DATA_W-1:0] data_out,               // Data from device
  input  wire logic                           data_oe,                // Data enable
  input  var  int                             wait_states,            // Waits to insert
  output logic                                ready,                  // Ready out
  output logic [ext_bus_pkg::DATA_W-1:0]      data_in                 // Data to device
);
  import ext_bus_pkg::*;
  logic [DATA_W-1:0] mem [3] = '{16'h0000, 16'h0000, 16'h0000}; // One word per space
  logic [DATA_W-1:0] wd_reg;  // Data seen while the strobe is low
  logic              we_reg;  // Last write strobe level
  logic [1:0]        sp_reg;  // Space of the running cycle
  logic [1:0]        sp;      // Space now selected
  int                cnt = 0; // Clocks since the strobe fell
  always_comb sp = !program_space_select_n ? 2'd0 : (!data_space_select_n ? 2'd1 : 2'd2);
  // Capture on the strobe's rise, since data may change with the release
  always @(posedge clk_sys)
  begin
    cnt <= bus_cycle_strobe_n ? 0 : cnt + 1;
    we_reg <= write_strobe_n;
    if (!bus_cycle_strobe_n) sp_reg <= sp;
    if (!write_strobe_n && data_oe) wd_reg <= data_out;
    if (write_strobe_n && !we_reg) mem[sp_reg] <= wd_reg;
  end
  // Ready held low for the asked machine cycles; high when idle like a pull-up
  assign ready = bus_cycle_strobe_n || (cnt >= 4 * wait_states - 1);
  // Undriven bus shows the inverse, so a stale value never passes
  assign data_in = (!read_strobe_n && !bus_cycle_strobe_n) ? mem[sp] : ~mem[sp];
endmodule // ext_mem_model
`default_nettype wire

// ---- verification/test_external_memory_bus_control.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_external_memory_bus_control;
  import ext_bus_pkg::*;
  logic clk_sys = 0, rstn = 0, output_off_n = 1, hold_req_n = 1, req = 0, req_wr = 0;
  logic req_glb = 0, mode_wr = 0, int_ctrl_wr = 0, ready, req_done, hold_active, rw_dir;
  logic rw_dir_oe, read_strobe_n, read_strobe_oe, write_strobe_n, write_strobe_oe, addr_oe;
  logic program_space_select_n, program_space_select_oe, data_space_select_n, data_oe;
  logic data_space_select_oe, io_space_select_n, io_space_select_oe, bus_cycle_strobe_n;
  logic bus_cycle_strobe_oe, global_bus_request_n, global_bus_request_oe;
  logic hold_acknowledge_n, hold_acknowledge_oe;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, cfg_wdata = 16'h0000;
  logic [15:0] data_in, rdata, addr_out, data_out;
  space_t req_space = SPACE_PROGRAM; // Target of the next access
  int wait_states = 0; // Waits the far side inserts
  int miscompares = 0;
  int num_checks = 0;
  ext_bus_ctrl ext_bus_ctrl_inst (.*);
  ext_mem_model ext_mem_model_inst (.*);
  always #2 clk_sys = ~clk_sys;
  task report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs move 1 ns after the edge, clear of the sampling instant
  task step;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    int i;
    for (i = 0; i < 100 && s !== v; i++) step;
    if (s !== v) begin miscompares++; report_and_stop; end
  endtask
  task cfg(input bit to_mode, input logic [15:0] v);
    cfg_wdata = v;
    if (to_mode) mode_wr = 1; else int_ctrl_wr = 1;
    step;
    mode_wr = 0;
    int_ctrl_wr = 0;
  endtask
  // One whole access; pins are sampled on the first strobe-low clock
  task automatic access(input bit wr, input space_t sp, input bit glb, input int w,
                        input logic [15:0] d);
    int i, n = 0;
    bit got = 0;
    logic [6:0] snap;
    logic [15:0] rd, ad;
    wait_states = w; req_wr = wr; req_space = sp; req_glb = glb;
    req_addr = 16'h0300 + 16'(sp); req_wdata = d; req = 1;
    for (i = 0; i < 300 && !(got && bus_cycle_strobe_n && n > 0); i++)
    begin
      step;
      if (!bus_cycle_strobe_n && ++n == 1) begin ad = addr_out; snap = {program_space_select_n,
        data_space_select_n, io_space_select_n, rw_dir, read_strobe_n, write_strobe_n,
        global_bus_request_n}; end
      if (req_done) begin req = 0; got = 1; rd = rdata; end
    end
    if (!got) begin miscompares++; report_and_stop; end
    // The far side stores on the write strobe's rise, one clock after the loop ends
    step;
    check(snap[6:4], {sp != SPACE_PROGRAM, sp != SPACE_DATA, sp != SPACE_IO});
    check(snap[3:1], {!wr, wr, !wr});
    check(snap[0], !(glb && sp == SPACE_DATA));
    check(ad, 16'h0300 + 16'(sp));
    check(n, 4 * (w + 1));
    if (wr) check(ext_mem_model_inst.mem[sp], d);
    else check(rd, d);
  endtask
  task t_idle(input logic oe);
    check({program_space_select_n, data_space_select_n, io_space_select_n, rw_dir,
           write_strobe_n, bus_cycle_strobe_n}, 6'h3F);
    check({program_space_select_oe, data_space_select_oe, io_space_select_oe, rw_dir_oe,
           read_strobe_oe, write_strobe_oe, bus_cycle_strobe_oe, global_bus_request_oe,
           hold_acknowledge_oe, addr_oe, data_oe}, oe ? 11'h7FE : 11'h000);
  endtask
  // Every space written then read back, with and without wait states
  task t_rw;
    for (int s = 0; s < 3; s++) access(1, space_t'(s), 0, 0, 16'hA5C0 + 16'(s));
    for (int s = 0; s < 3; s++) access(0, space_t'(s), 0, s, 16'hA5C0 + 16'(s));
    access(1, SPACE_DATA, 1, 1, 16'h1234);
    access(0, SPACE_DATA, 1, 0, 16'h1234);
  endtask
  // Read pin as inverted direction, then back to the read strobe
  task t_read_pin;
    cfg(1, 16'h8000);
    step;
    check(read_strobe_n, !rw_dir);
    access(0, SPACE_PROGRAM, 0, 0, 16'hA5C0);
    access(1, SPACE_IO, 0, 2, 16'h0F0F);
    cfg(1, 16'h0000);
    step;
    check(read_strobe_n, 1'b1);
  endtask
  // Output disable floats every pin, and lifting it drives all but the data pins again
  task t_off;
    output_off_n = 0;
    step;
    step;
    t_idle(0);
    output_off_n = 1;
    step;
    step;
    t_idle(1);
  endtask
  // Hold ignored in interrupt mode, taken in hold mode, then left
  task t_hold;
    cfg(0, 16'h0001);
    hold_req_n = 0;
    repeat (12) step;
    check(hold_active, 1'b0);
    cfg(0, 16'h0000);
    wait_lvl(hold_acknowledge_n, 1'b0);
    check({hold_active, hold_acknowledge_oe, addr_oe, data_oe, program_space_select_oe},
          5'h18);
    hold_req_n = 1;
    wait_lvl(hold_acknowledge_n, 1'b1);
    access(0, SPACE_IO, 0, 0, 16'h0F0F);
  endtask
  initial
  begin
    repeat (4) step;
    rstn = 1;
    step;
    t_idle(1);
    t_rw;
    t_read_pin;
    t_off;
    t_hold;
    report_and_stop;
  end
endmodule // test_external_memory_bus_control
`default_nettype wire
